// File: hw/ipv_cfg.svh
// Constants for the interrupt priority and vectoring block.
// Assumes inclusion by bare name from the design; the package does not include it.
`ifndef IPV_CFG_SVH
`define IPV_CFG_SVH
`define IPV_VEC_RESET 16'hFFFE
`define IPV_VEC_NMI 16'hFFFC
`define IPV_VEC_SWI 16'hFFFA
`define IPV_VEC_EXT 16'hFFF8
`define IPV_VEC_ICF 16'hFFF6
`define IPV_VEC_OCF 16'hFFF4
`define IPV_VEC_TOF 16'hFFF2
`define IPV_VEC_SCI 16'hFFF0
`define IPV_MODE0_HIGH 4'hB
`define IPV_STACK_BYTES 4'h7
`define IPV_CLK_DIV 2'h3
`define IPV_EDIV_HALF 2'h2
`endif

// File: hw/ipv_pkg.sv
// Types shared by the interrupt priority and vectoring block.
// Assumes nothing; uses none of the constants header.
package ipv_pkg;
  typedef enum logic [3:0] {
    IPV_SRC_NONE, IPV_SRC_NMI, IPV_SRC_SWI, IPV_SRC_EXT,
    IPV_SRC_ICF, IPV_SRC_OCF, IPV_SRC_TOF, IPV_SRC_SCI
  } ipv_src_e;
  typedef struct packed {
    logic icf;
    logic ocf;
    logic tof;
    logic sci;
  } ipv_int_s;
  typedef enum logic [1:0] {IPV_IDLE, IPV_STACK, IPV_VECHI, IPV_VECLO} ipv_state_e;
endpackage

// File: hw/ipv_ctrl.sv
// Interrupt recognition, priority, stacking sequence and vector select.
// Assumes the sequencer reports instruction boundaries and stack loads
// on the same clock; pins from outside pass two flip-flops first.
`include "ipv_cfg.svh"

// Functional notes
// RQ1 - NMI taken regardless of mask, at boundary
// RQ2 - Maskable requests gated by mask and enables
// RQ3 - Timer and serial merged onto internal line
// RQ4 - External maskable served before internal maskable
// RQ5 - NMI held until first stack load
// RQ6 - Internal sources fixed priority, own vectors
// RQ7 - Vector table; mode 0 moves to BFFx
// RQ8 - Stack PC, X, A, B, CCR on entry
// RQ9 - Set mask, fetch vector, resume
// RQ10 - External request level sensitive, vector FFF8
// RQ11 - NMI falling edge makes one request
// RQ12 - Reset held low three bus cycles
// RQ13 - Bus clock is input clock divided four
// RQ14 - Strobe flag requests only when enabled
// RQ15 - NMI latch cleared on vector fetch
// RQ16 - Internal line needs flag and enable
module ipv_ctrl (
  input wire logic clk, // Input clock, four per bus cycle
  input wire logic rst_b, // Synchronous reset, active low
  input wire logic nmiPin_b, // Non-maskable request pin, active low
  input wire logic extReqPin_b, // External maskable request pin, active low
  input wire logic portStrobeFlag, // Port strobe flag
  input wire logic portStrobeIrqEn, // Port strobe interrupt enable
  input wire ipv_pkg::ipv_int_s intFlag, // Timer and serial status flags
  input wire ipv_pkg::ipv_int_s intEn, // Timer and serial enables
  input wire logic instrDone, // Pulse: instruction boundary
  input wire logic swiReq, // Pulse: software interrupt at boundary
  input wire logic spLoad, // Pulse: program loads stack pointer
  input wire logic mode0, // Mode 0 vector relocation
  input wire logic maskSet, // Pulse: software sets mask bit
  input wire logic maskClr, // Pulse: software clears mask bit
  output logic eClk, // Bus clock, input clock divided by four
  output logic maskBit, // Condition code mask bit
  output logic internalMaskableRequest, // Internal maskable line, active high
  output logic seqBusy, // Sequence in progress, stall instructions
  output logic stackPush, // Pulse: push one stacked byte
  output logic [2:0] stackIdx, // Byte index 0 PCL .. 6 CCR
  output logic vecFetch, // Pulse: vector address valid
  output logic [15:0] vecAddr, // Vector byte address
  output logic pcLoad // Pulse: vector loaded into PC, resume
);
  logic [1:0] div_q;
  logic [1:0] nmiSync_q, extSync_q;
  logic nmiPrev_q, nmiLatch_q, nmiArmed_q;
  logic [2:0] cnt_q;
  ipv_pkg::ipv_state_e state_q;
  ipv_pkg::ipv_src_e src_q, srcSel;
  logic eRise, extActive, externalMaskableRequest, takeNow;

  function automatic logic [15:0] relocate(input logic [15:0] v, input logic m0);
    relocate = m0 ? {`IPV_MODE0_HIGH, v[11:0]} : v;
  endfunction

  always_ff @(posedge clk) begin
    if (!rst_b) div_q <= 2'h0;
    else div_q <= div_q + 2'h1; // RQ13
  end
  assign eClk = div_q[1];
  // Sequencing after entry advances once per bus cycle
  assign eRise = (div_q == `IPV_CLK_DIV); // RQ13

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      nmiSync_q <= 2'h3;
      extSync_q <= 2'h3;
    end else begin
      nmiSync_q <= {nmiSync_q[0], nmiPin_b};
      extSync_q <= {extSync_q[0], extReqPin_b};
    end
  end

  assign extActive = !extSync_q[1]; // RQ10
  assign externalMaskableRequest = extActive | (portStrobeFlag & portStrobeIrqEn); // RQ14
  assign internalMaskableRequest = |(intFlag & intEn); // RQ3 RQ16

  // Edge latch; a new edge in the fetch cycle wins over the clear
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      nmiPrev_q <= 1'b1;
      nmiLatch_q <= 1'b0;
    end else begin
      nmiPrev_q <= nmiSync_q[1];
      if (nmiPrev_q && !nmiSync_q[1]) nmiLatch_q <= 1'b1; // RQ11
      else if (vecFetch && src_q == ipv_pkg::IPV_SRC_NMI) nmiLatch_q <= 1'b0; // RQ15
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) nmiArmed_q <= 1'b0;
    else if (spLoad) nmiArmed_q <= 1'b1; // RQ5
  end

  always_comb begin
    srcSel = ipv_pkg::IPV_SRC_NONE;
    if (nmiLatch_q && nmiArmed_q) srcSel = ipv_pkg::IPV_SRC_NMI; // RQ1 RQ5
    else if (swiReq) srcSel = ipv_pkg::IPV_SRC_SWI;
    else if (!maskBit && externalMaskableRequest) srcSel = ipv_pkg::IPV_SRC_EXT; // RQ2 RQ4
    else if (!maskBit && internalMaskableRequest) begin // RQ2 RQ6
      if (intFlag.icf && intEn.icf) srcSel = ipv_pkg::IPV_SRC_ICF;
      else if (intFlag.ocf && intEn.ocf) srcSel = ipv_pkg::IPV_SRC_OCF;
      else if (intFlag.tof && intEn.tof) srcSel = ipv_pkg::IPV_SRC_TOF;
      else srcSel = ipv_pkg::IPV_SRC_SCI;
    end
  end
  // Only at an instruction boundary, so the current one completes
  assign takeNow = (state_q == ipv_pkg::IPV_IDLE) && instrDone &&
                   (srcSel != ipv_pkg::IPV_SRC_NONE); // RQ1

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      state_q <= ipv_pkg::IPV_IDLE;
      cnt_q <= 3'h0;
      src_q <= ipv_pkg::IPV_SRC_NONE;
    end else begin
      unique case (state_q)
        ipv_pkg::IPV_IDLE: begin
          cnt_q <= 3'h0;
          if (takeNow) begin
            src_q <= srcSel;
            state_q <= ipv_pkg::IPV_STACK;
          end
        end
        ipv_pkg::IPV_STACK: if (eRise) begin
          if (cnt_q == 3'(`IPV_STACK_BYTES - 4'h1)) state_q <= ipv_pkg::IPV_VECHI; // RQ8
          else cnt_q <= cnt_q + 3'h1;
        end
        ipv_pkg::IPV_VECHI: if (eRise) state_q <= ipv_pkg::IPV_VECLO;
        ipv_pkg::IPV_VECLO: if (eRise) state_q <= ipv_pkg::IPV_IDLE; // RQ9
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) maskBit <= 1'b1;
    else if (state_q == ipv_pkg::IPV_VECHI && eRise) maskBit <= 1'b1; // RQ9
    else if (maskSet) maskBit <= 1'b1;
    else if (maskClr) maskBit <= 1'b0;
  end

  always_ff @(posedge clk) begin
    if (!rst_b) vecAddr <= 16'h0000;
    else if (state_q == ipv_pkg::IPV_STACK) begin
      unique case (src_q)
        ipv_pkg::IPV_SRC_NMI: vecAddr <= relocate(`IPV_VEC_NMI, mode0); // RQ7
        ipv_pkg::IPV_SRC_SWI: vecAddr <= relocate(`IPV_VEC_SWI, mode0);
        ipv_pkg::IPV_SRC_EXT: vecAddr <= relocate(`IPV_VEC_EXT, mode0); // RQ10
        ipv_pkg::IPV_SRC_ICF: vecAddr <= relocate(`IPV_VEC_ICF, mode0); // RQ6
        ipv_pkg::IPV_SRC_OCF: vecAddr <= relocate(`IPV_VEC_OCF, mode0);
        ipv_pkg::IPV_SRC_TOF: vecAddr <= relocate(`IPV_VEC_TOF, mode0);
        ipv_pkg::IPV_SRC_SCI: vecAddr <= relocate(`IPV_VEC_SCI, mode0);
        default: vecAddr <= relocate(`IPV_VEC_RESET, mode0);
      endcase
    end else if (state_q == ipv_pkg::IPV_VECHI && eRise) begin
      vecAddr <= vecAddr | 16'h0001;
    end
  end

  assign seqBusy = (state_q != ipv_pkg::IPV_IDLE);
  assign stackPush = (state_q == ipv_pkg::IPV_STACK) && eRise; // RQ8
  assign stackIdx = cnt_q;
  assign vecFetch = (state_q == ipv_pkg::IPV_VECHI) && eRise; // RQ9
  assign pcLoad = (state_q == ipv_pkg::IPV_VECLO) && eRise; // RQ9
endmodule

// File: sim/ipv_ctrl_properties.sv
// Checker of vector, stacking and bus clock relations at the ports.
// Assumes a bind onto ipv_ctrl; sees only its ports.
module ipv_ctrl_chk (
  input wire logic clk, // Input clock
  input wire logic rst_b, // Reset, active low
  input wire logic mode0, // Relocation
  input wire ipv_pkg::ipv_int_s intFlag, // Flags
  input wire ipv_pkg::ipv_int_s intEn, // Enables
  input wire logic internalMaskableRequest, // Merged line
  input wire logic eClk, // Bus clock
  input wire logic maskBit, // Mask
  input wire logic seqBusy, // Busy
  input wire logic stackPush, // Push
  input wire logic [2:0] stackIdx, // Byte index
  input wire logic vecFetch, // Fetch
  input wire logic [15:0] vecAddr, // Vector
  input wire logic pcLoad // Resume
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  a_push_follows: assert property ($rose(seqBusy) |-> ##[1:4] stackPush)
    else $error("no push after entry");
  a_busy_holds: assert property ($rose(seqBusy) |-> seqBusy[*8])
    else $error("sequence ended early");
  a_idx_range: assert property (stackPush |-> stackIdx <= 3'h6)
    else $error("stack index out of range");
  a_vec_table: assert property (vecFetch |-> vecAddr[15:4] == (mode0 ? 12'hBFF : 12'hFFF))
    else $error("vector outside table");
  a_lo_follows: assert property (vecFetch |-> !vecAddr[0] ##4 (pcLoad && vecAddr[0]))
    else $error("vector byte order wrong");
  a_mask_set: assert property (vecFetch |=> maskBit)
    else $error("mask not set");
  a_resume_idle: assert property (pcLoad |=> !seqBusy)
    else $error("no resume after load");
  a_int_merge: assert property (internalMaskableRequest == |(intFlag & intEn))
    else $error("internal line wrong");
  a_eclk_div: assert property ($rose(eClk) |=> eClk ##1 !eClk[*2] ##1 eClk)
    else $error("bus clock not divide by four");
  cover property (vecFetch && mode0);
  cover property (vecFetch && vecAddr[3:0] == 4'hC);
  cover property (pcLoad && internalMaskableRequest);
endmodule
bind ipv_ctrl ipv_ctrl_chk u_ipv_ctrl_chk (.clk, .rst_b, .mode0, .intFlag, .intEn,
  .internalMaskableRequest, .eClk, .maskBit, .seqBusy, .stackPush, .stackIdx, .vecFetch,
  .vecAddr, .pcLoad);

// File: sim/ipv_src_model.sv
// Far-side sources: non-maskable pin and shared external request line.
// Assumes bench commands on the same clock.
module ipv_src_model (
  input wire logic clk, // Input clock
  input wire logic nmiGo, // Pulse: one falling edge
  input wire logic extOn, // Hold external line low
  output logic nmiPin_b, // Non-maskable pin
  output logic extReqPin_b // External line, pulled up
);
  timeunit 1ns;
  timeprecision 1ns;
  int lowCnt = 0;
  // Held low long to show a level alone gives no repeat
  always @(posedge clk) begin
    if (nmiGo) lowCnt <= 400;
    else if (lowCnt > 0) lowCnt <= lowCnt - 1;
  end
  assign nmiPin_b = (lowCnt == 0);
  assign extReqPin_b = !extOn;
endmodule

// File: sim/tb.sv
// Self-checking bench for interrupt recognition and vector choice.
// Assumes the source model and the bound checker.
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 0, rst_b = 0, nmiGo = 0, extOn = 0, portStrobeFlag = 0, portStrobeIrqEn = 0;
  logic instrDone = 0, swiReq = 0, spLoad = 0, mode0 = 0, maskSet = 0, maskClr = 0;
  logic nmiPin_b, extReqPin_b, seqBusy, vecFetch, pcLoad, maskBit;
  logic [15:0] vecAddr;
  logic [15:0] expQ[$];
  ipv_pkg::ipv_int_s intFlag = '0, intEn = '0;
  int err_count = 0, check_count = 0;
  always #25 clk = ~clk;
  ipv_src_model u_ipv_src_model (.clk, .nmiGo, .extOn, .nmiPin_b, .extReqPin_b);
  ipv_ctrl u_ipv_ctrl (.clk, .rst_b, .nmiPin_b, .extReqPin_b, .portStrobeFlag,
    .portStrobeIrqEn, .intFlag, .intEn, .instrDone, .swiReq, .spLoad, .mode0, .maskSet,
    .maskClr, .eClk(), .maskBit, .internalMaskableRequest(), .seqBusy, .stackPush(),
    .stackIdx(), .vecFetch, .vecAddr, .pcLoad);
  task automatic chk(string n, logic [15:0] seen, logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic pulse(ref logic s);
    s = 1;
    @(posedge clk) #2 s = 0;
  endtask
  // Lets synchronisers settle, then waits out any sequence
  task automatic boundary(logic [15:0] exp, logic svc);
    int i;
    if (svc) expQ.push_back(exp);
    repeat (4) @(posedge clk);
    #2 pulse(instrDone);
    for (i = 0; i < 80 && (seqBusy !== 1'b0 || i < 2); i++) @(posedge clk);
    #2;
    if (i == 80) begin
      err_count++;
      test_done();
    end
  endtask
  function automatic logic [3:0] pick(logic e, logic [3:0] m);
    if (e) return 4'h8;
    for (int b = 3; b >= 0; b--)
      if (m[b]) return 4'(2 * b);
    return 4'h0;
  endfunction
  // Strobes are combinational off registers, so look mid-cycle, away from the launching edge
  always @(negedge clk) begin
    if (vecFetch) chk("vecAddr", vecAddr, expQ.size() ? expQ.pop_front() : 16'hDEAD);
    if (pcLoad) chk("maskBit", 16'(maskBit), 16'h0001);
  end
  initial begin
    logic e;
    void'($urandom(32'h144d26a2));
    repeat (12) @(posedge clk);
    #2 rst_b = 1;
    pulse(nmiGo);
    boundary(16'hFFFC, 0);
    pulse(spLoad);
    boundary(16'hFFFC, 1);
    boundary(16'hFFFC, 0);
    $display("test nmi done");
    extOn = 1;
    boundary(16'hFFF8, 0);
    for (int k = 0; k < 16; k++) begin
      pulse(maskClr);
      mode0 = k[0];
      {extOn, portStrobeFlag, portStrobeIrqEn} = 3'($urandom);
      intFlag = 4'($urandom);
      intEn = 4'($urandom);
      e = extOn | (portStrobeFlag & portStrobeIrqEn);
      boundary({mode0 ? 12'hBFF : 12'hFFF, pick(e, intFlag & intEn)}, e | |(intFlag & intEn));
    end
    $display("test priority done");
    swiReq = 1;
    boundary(16'hBFFA, 1);
    swiReq = 0;
    pulse(maskClr);
    pulse(maskSet);
    extOn = 1;
    boundary(16'hBFF8, 0);
    chk("pending", 16'(expQ.size()), 16'h0000);
    $display("test mask done");
    test_done();
  end
endmodule
